// *** include/rac_pkg.sv ***
// Package for the register access type cells: access kinds, request carrier, reset values
package rac_pkg;

  // Per-bit access kinds
  typedef enum logic [3:0] {
    RAC_HARDWARE_INITIALIZED,     // hardware_initialized
    RAC_RC,         // read_to_clear
    RAC_RCW,        // read_clear_writable
    RAC_RSVD,       // reserved
    RAC_RO,         // read only (constant or hardware status)
    RAC_RW,         // plain read-write
    RAC_W1C,        // write_one_clear
    RAC_RWL,        // lock_gated_writable
    RAC_ROS,        // sticky_read_only
    RAC_RWS,        // sticky_read_write
    RAC_W1CS,       // sticky_write_one_clear
    RAC_WT,         // write_transient_qualifier
    RAC_ZERO        // zero bit
  } rac_kind_t;

  // Accessor sources; all are treated the same by the cells
  typedef enum logic [1:0] {
    RAC_SRC_CFG,
    RAC_SRC_SMB,
    RAC_SRC_EEP
  } rac_src_t;

  localparam int RAC_WIDTH = 32;  // Default register width

  // One software access to the register
  typedef struct packed {
    logic                 rd;     // Read strobe, one cycle
    logic                 wr;     // Write strobe, one cycle
    rac_src_t             src;    // Which accessor
    logic [RAC_WIDTH-1:0] wdata;  // Write data
  } rac_req_t;

  // Reset kinds
  typedef struct packed {
    logic hot;    // Hot reset, one cycle or level
    logic fund;   // Fundamental reset, one cycle or level
    logic aux;    // Auxiliary power present
  } rac_rst_t;

  localparam logic [RAC_WIDTH-1:0] RAC_ZERO_WORD = 32'h0000_0000;

endpackage

// *** logic/rac_bit_cell.sv ***
// Single storage bit whose next value depends on its access kind
`timescale 1ns/1ps
// Operation
// - All accessors obey the same bit rules
// - Hardware-initialized bits load init_val whenever init_en is high, else read-only
// - Read clears bit; writes discarded
// - Read clears bit; write loads value
// - Reserved bits masked and written back
// - Read-write bits take written value
// - Writing one clears status bit
// - Only hardware sets, never clears status
// - Lock-gated bits written only while unlocked
// - Lock-gated bits survive hot reset only
// - Sticky read-only bits ignore hot reset
// - Sticky read-write bits ignore hot reset
// - Sticky one-clear bits ignore hot reset
// - Persistent sticky bits survive fundamental reset while aux power is present
// - Write-transient bit reads zero, qualifies writes
// - Zero bits read zero, written zero
module rac_bit_cell
  import rac_pkg::*;
(
  input  wire logic      ref_clk,
  input  wire logic      reset,
  input  rac_pkg::rac_kind_t kind,
  input  wire logic      dflt,
  input  wire logic      frs,
  input  wire logic      init_en,
  input  wire logic      init_val,
  input  wire logic      hw_set,
  input  wire logic      hw_clr,
  input  wire logic      hw_val,
  input  wire logic      sw_rd,
  input  wire logic      sw_wr,
  input  wire logic      sw_bit,
  input  wire logic      unlock,
  input  wire logic      hot_rst,
  input  wire logic      fund_rst,
  input  wire logic      aux_pwr,
  output logic           val_q
);
  logic val_d;                                   // Next stored value
  logic is_sticky;                               // Survives hot reset
  logic keep_fund;                               // Survives fundamental reset
  logic zero_kind;                               // Kinds that never store anything
  logic rst_val;                                 // Value loaded by a hot or fundamental reset that reaches the bit

  assign is_sticky = (kind == RAC_ROS) || (kind == RAC_RWS) || (kind == RAC_W1CS)
                     || (kind == RAC_RWL);
  assign keep_fund = (kind != RAC_RWL) && is_sticky && frs && aux_pwr;
  // Zero-type kinds must not pick up a non-zero default on reset
  assign zero_kind = (kind == RAC_RSVD) || (kind == RAC_WT) || (kind == RAC_ZERO);
  assign rst_val   = zero_kind ? 1'b0 : dflt;

  // Next-value selection per kind; accessor source is not looked at
  always_comb begin
    val_d = val_q;
    unique case (kind)
      RAC_HARDWARE_INITIALIZED: begin
        if (init_en) begin
          val_d = init_val;
        end
      end
      RAC_RC: begin
        if (sw_rd) begin
          val_d = 1'b0;
        end
        if (hw_set) begin
          val_d = 1'b1;
        end
      end
      RAC_RCW: begin
        if (sw_rd) begin
          val_d = 1'b0;
        end
        if (sw_wr) begin
          val_d = sw_bit;
        end
        if (hw_set) begin
          val_d = 1'b1;
        end
      end
      RAC_RO, RAC_ROS: begin
        // Software writes ignored; hardware owns the value
        if (hw_set) begin
          val_d = 1'b1;
        end else if (hw_clr) begin
          val_d = 1'b0;
        end
      end
      RAC_RW, RAC_RWS: begin
        if (sw_wr) begin
          val_d = sw_bit;
        end
      end
      RAC_W1C, RAC_W1CS: begin
        if (sw_wr && sw_bit) begin
          val_d = 1'b0;
        end
        if (hw_set) begin
          val_d = 1'b1;
        end
      end
      RAC_RWL: begin
        if (sw_wr && unlock) begin
          val_d = sw_bit;
        end
      end
      RAC_RSVD, RAC_WT, RAC_ZERO: begin
        val_d = 1'b0;
      end
      default: begin
        val_d = val_q;
      end
    endcase
  end

  // Storage with reset priority: block reset, fundamental, then hot
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      val_q <= 1'b0;
    end else if (fund_rst && !keep_fund) begin
      val_q <= rst_val;
    end else if (fund_rst) begin
      val_q <= val_q;
    end else if (hot_rst && !is_sticky) begin
      val_q <= rst_val;
    end else begin
      val_q <= val_d;
    end
  end

  // Hardware level input kept for wider status cells; this cell only uses set and clear
  logic unused_hw_val;
  assign unused_hw_val = hw_val;
endmodule

// *** tb/rac_bit_cell_monitor.sv ***
// Checker on the bit cell ports
`timescale 1ns/1ps
module rac_mon import rac_pkg::*; (
  input wire logic ref_clk, reset, sw_rd, sw_wr, sw_bit, unlock, hot_rst, fund_rst, hw_set, hw_clr, val_q,
  input rac_kind_t kind
);
  wire logic q = !hot_rst && !fund_rst && !hw_set && !hw_clr; // Quiet: no reset, no hardware event
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  property p_rc; q && kind == RAC_RC && sw_rd |=> !val_q; endproperty
  a_rc: assert property (p_rc) else $error("read clear");
  property p_ro; q && kind inside {RAC_RC, RAC_RO, RAC_ROS} && sw_wr && !sw_rd |=> $stable(val_q); endproperty
  a_ro: assert property (p_ro) else $error("write not ignored");
  property p_rw; q && kind inside {RAC_RW, RAC_RWS, RAC_RCW} && sw_wr && !sw_rd |=> val_q == $past(sw_bit); endproperty
  a_rw: assert property (p_rw) else $error("write lost");
  property p_w1c; q && kind inside {RAC_W1C, RAC_W1CS} && sw_wr |=> val_q == $past(val_q && !sw_bit); endproperty
  a_w1c: assert property (p_w1c) else $error("one clear");
  property p_set; !hot_rst && !fund_rst && hw_set && kind inside {RAC_RC, RAC_W1C, RAC_W1CS} |=> val_q; endproperty
  a_set: assert property (p_set) else $error("set lost");
  property p_rwl; q && kind == RAC_RWL && sw_wr |=> val_q == $past(unlock ? sw_bit : val_q); endproperty
  a_rwl: assert property (p_rwl) else $error("lock gate");
  // Sticky kinds must ride through hot reset untouched
  property p_hot; hot_rst && !fund_rst && !sw_wr && !hw_set && !hw_clr
    && kind inside {RAC_RWL, RAC_ROS, RAC_RWS, RAC_W1CS} |=> $stable(val_q); endproperty
  a_hot: assert property (p_hot) else $error("hot reset");
  property p_zero; kind inside {RAC_RSVD, RAC_WT, RAC_ZERO} && $stable(kind) |-> !val_q; endproperty
  a_zero: assert property (p_zero) else $error("zero bit");
  c_set: cover property (hw_set && sw_wr && sw_bit);
  c_lock: cover property (kind == RAC_RWL && sw_wr && !unlock);
  c_hot: cover property (hot_rst && kind == RAC_W1CS && val_q);
endmodule
bind rac_bit_cell rac_mon u_mon (.ref_clk, .reset, .sw_rd, .sw_wr, .sw_bit, .unlock, .hot_rst, .fund_rst,
  .hw_set, .hw_clr, .val_q, .kind);

// *** tb/testbench.sv ***
// Random bench comparing the bit cell with a model
`timescale 1ns/1ps
module testbench;
  import rac_pkg::*;
  logic ref_clk = 0, reset = 1, dflt, frs, init_en = 0, init_val, hw_set = 0, hw_clr = 0, hw_val;
  logic sw_rd = 0, sw_wr = 0, sw_bit = 0, unlock = 0, hot_rst = 0, fund_rst = 0, aux_pwr = 0, val_q, e;
  logic [31:0] r;
  rac_kind_t kind = RAC_RW;
  rac_kind_t ks[13] = '{RAC_HARDWARE_INITIALIZED, RAC_RC, RAC_RCW, RAC_RSVD, RAC_RO, RAC_RW, RAC_W1C, RAC_RWL, RAC_ROS, RAC_RWS,
    RAC_W1CS, RAC_WT, RAC_ZERO};
  logic stk, keep;  // Model: kind survives hot reset, bit survives fundamental reset
  int seed = 32'h3e1f_bf1f, n_mismatch = 0, checked = 0;
  rac_bit_cell uut (.ref_clk, .reset, .kind, .dflt, .frs, .init_en, .init_val, .hw_set, .hw_clr, .hw_val,
    .sw_rd, .sw_wr, .sw_bit, .unlock, .hot_rst, .fund_rst, .aux_pwr, .val_q);
  always #5 ref_clk = ~ref_clk;
  task finish_test;
    if (n_mismatch == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Watchdog well past the 3900 cycles of traffic
  initial begin
    #100000 n_mismatch++;
    finish_test;
  end
  // Each kind: one reset cycle, then random reads, writes, sets
  initial begin
    {dflt, frs, init_val, hw_val} = 0;
    repeat (8) @(posedge ref_clk);
    foreach (ks[i]) begin
      #1 {reset, sw_rd, sw_wr, hw_set, hot_rst, fund_rst, hw_clr, init_en} = 8'h80;
      kind = ks[i];
      e = 0;
      @(posedge ref_clk);
      #1 reset = 0;
      repeat (300) begin
        r = $random(seed);
        {dflt, frs, init_val, hw_val, sw_bit, unlock} = r[5:0];
        // Software writes zero, or the value read back, to reserved and zero bits
        if (kind inside {RAC_RSVD, RAC_ZERO}) sw_bit = 0;
        hot_rst = r[6];
        fund_rst = r[12:10] == 0;
        aux_pwr = r[13];
        init_en = r[14];
        hw_set = r[7] && kind inside {RAC_RC, RAC_RCW, RAC_RO, RAC_ROS, RAC_W1C, RAC_W1CS};
        hw_clr = r[15] && kind inside {RAC_RO, RAC_ROS};
        sw_rd = r[9:8] == 1 && !hot_rst;
        sw_wr = r[9:8] == 2 && !hot_rst;
        stk = kind inside {RAC_RWL, RAC_ROS, RAC_RWS, RAC_W1CS};
        keep = kind inside {RAC_ROS, RAC_RWS, RAC_W1CS} && frs && aux_pwr;
        if (fund_rst) e = keep ? e : dflt && !(kind inside {RAC_RSVD, RAC_WT, RAC_ZERO});
        else if (hot_rst && !stk) e = dflt && !(kind inside {RAC_RSVD, RAC_WT, RAC_ZERO});
        else case (kind)
          RAC_HARDWARE_INITIALIZED: e = init_en ? init_val : e;
          RAC_RC: e = hw_set | (e & !sw_rd);
          RAC_RCW: e = hw_set | (sw_wr ? sw_bit : e & !sw_rd);
          RAC_RO, RAC_ROS: e = hw_set | (e & !hw_clr);
          RAC_RW, RAC_RWS: e = sw_wr ? sw_bit : e;
          RAC_W1C, RAC_W1CS: e = hw_set | (e & !(sw_wr & sw_bit));
          RAC_RWL: e = sw_wr & unlock ? sw_bit : e;
          default: e = 0;
        endcase
        @(posedge ref_clk);
        #1 if (val_q !== e) begin
          n_mismatch++;
          $display("Error val_q kind %0d expected %b seen %b", kind, e, val_q);
        end
        checked++;
      end
    end
    finish_test;
  end
endmodule
